/* File: src/miimac_pins.sv */
`timescale 1ns/1ps
// Operation
// - names ending in _n or _b are asserted low, all others asserted high.
// - receive nibbles are accepted only while receive data valid is high.
// - one four-bit receive nibble is captured per receive clock cycle.
// - transmit data goes to the phy as a four-bit nibble.
// - in a frame during which receive error is seen, nibbles from the error on are not passed out.
// - such a frame is reported with the bad crc flag, status bit 13.
// - phy select is driven low on host accesses to the eight lowest addresses in bank 7.
// - transmit envelope is high for the whole transmitted frame.
// - carrier sense gates transmit start for deferral; a collision is only reported on tx_collision.
module miimac_pins
    import miimac_pkg::*;
#(
    parameter int DEPTH = FIFO_DEPTH
) (
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic tx_nibble_clock,
    input wire logic rx_nibble_clock,
    output logic [NIBBLE_W-1:0] tx_data_out,
    output logic tx_envelope_out,
    input wire logic carrier_sense_in,
    input wire logic collision_in,
    input wire logic rx_valid_in,
    input wire logic rx_error_in,
    input wire logic [NIBBLE_W-1:0] rx_data_in,
    input wire logic tx_in_valid,
    output logic tx_in_ready,
    input wire miimac_tx_word_t tx_in_word,
    output logic [NIBBLE_W-1:0] rx_nibble,
    output logic rx_nibble_valid,
    output logic rx_frame_done,
    output logic rx_frame_good,
    output miimac_rx_report_t rx_report,
    output logic tx_collision,
    input wire logic host_access,
    input wire logic [LOW_ADDR_W:0] host_addr,
    input wire logic [BANK_W-1:0] host_bank,
    output logic phy_select_out_n
);

    // ****************************************************************
    // local types and decoders
    // ****************************************************************
    typedef enum {TX_IDLE, TX_SEND} miimac_tx_state_t;
    typedef enum {RX_IDLE, RX_RECV} miimac_rx_state_t;

    // rising edge of a synchronised link clock
    function automatic logic rising(input logic level, input logic last_level);
        return level && !last_level;
    endfunction

    // host access that falls in the phy window of the phy bank
    function automatic logic in_phy_window(input logic acc, input logic [LOW_ADDR_W:0] addr,
        input logic [BANK_W-1:0] bank);
        return acc && !addr[LOW_ADDR_W] && (bank == PHY_BANK);
    endfunction

    function automatic logic [STATUS_W-1:0] rx_status(input logic bad, input logic odd);
        logic [STATUS_W-1:0] word;
        word = STATUS_RESET;
        word[STAT_CRC_BIT] = bad;
        word[STAT_ODD_BIT] = odd;
        return word;
    endfunction

    logic [PIN_SYNC_W-1:0] pin_raw;
    logic [PIN_SYNC_W-1:0] pin_meta;
    logic [PIN_SYNC_W-1:0] pin_sync;
    logic txc_prev;
    logic rxc_prev;
    logic tx_edge;
    logic rx_edge;
    logic crs_s;
    logic col_s;
    logic dv_s;
    logic er_s;
    logic [NIBBLE_W-1:0] rxd_s;

    miimac_tx_state_t tx_state;
    miimac_tx_state_t next_tx_state;
    logic [NIBBLE_W-1:0] next_tx_data_out;
    logic next_tx_envelope_out;
    logic tx_last_sent;
    logic next_tx_last_sent;
    logic next_tx_collision;
    logic next_tx_in_ready;
    logic tx_push;
    logic tx_pop;
    logic fifo_in_ready;
    logic fifo_out_valid;
    miimac_tx_word_t tx_head;

    miimac_rx_state_t rx_state;
    miimac_rx_state_t next_rx_state;
    logic [COUNT_W-1:0] rx_count;
    logic [COUNT_W-1:0] next_rx_count;
    logic rx_err;
    logic next_rx_err;
    logic [NIBBLE_W-1:0] next_rx_nibble;
    logic next_rx_nibble_valid;
    logic next_rx_frame_done;
    logic next_rx_frame_good;
    miimac_rx_report_t next_rx_report;
    logic next_phy_select_out_n;

    // ****************************************************************
    // pin synchronisers and link clock edges
    // ****************************************************************
    assign pin_raw = {tx_nibble_clock, rx_nibble_clock, carrier_sense_in, collision_in,
        rx_valid_in, rx_error_in, rx_data_in};

    // data and clock pass the same two stages, so data is settled when the edge is seen
    genvar gi;
    generate
        for (gi = 0; gi < PIN_SYNC_W; gi++) begin : g_sync
            always_ff @(posedge mclk or negedge rst_b) begin
                if (!rst_b) begin
                    pin_meta[gi] <= PIN_SYNC_RESET[gi];
                    pin_sync[gi] <= PIN_SYNC_RESET[gi];
                end else begin
                    pin_meta[gi] <= pin_raw[gi];
                    pin_sync[gi] <= pin_meta[gi];
                end
            end
        end
    endgenerate

    // previous levels reset to the idle level so no false edge follows reset
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            txc_prev <= PIN_SYNC_RESET[SYNC_TXC_BIT];
            rxc_prev <= PIN_SYNC_RESET[SYNC_RXC_BIT];
        end else begin
            txc_prev <= pin_sync[SYNC_TXC_BIT];
            rxc_prev <= pin_sync[SYNC_RXC_BIT];
        end
    end

    assign tx_edge = rising(pin_sync[SYNC_TXC_BIT], txc_prev);
    assign rx_edge = rising(pin_sync[SYNC_RXC_BIT], rxc_prev);
    assign crs_s = pin_sync[SYNC_CRS_BIT];
    assign col_s = pin_sync[SYNC_COL_BIT];
    assign dv_s = pin_sync[SYNC_DV_BIT];
    assign er_s = pin_sync[SYNC_ER_BIT];
    assign rxd_s = pin_sync[NIBBLE_W-1:0];

    // ****************************************************************
    // transmit path
    // ****************************************************************
    assign tx_push = tx_in_valid && tx_in_ready;

    miimac_fifo #(
        .WIDTH($bits(miimac_tx_word_t)),
        .DEPTH(DEPTH)
    ) fifo_u (
        .mclk(mclk),
        .rst_b(rst_b),
        .in_valid(tx_push),
        .in_ready(fifo_in_ready),
        .in_data(tx_in_word),
        .out_valid(fifo_out_valid),
        .out_ready(tx_pop),
        .out_data(tx_head)
    );

    // ready is registered, so it drops for one cycle after each push:
    // half the host rate, still far above nibble rate
    always_comb begin
        next_tx_state = tx_state;
        next_tx_data_out = tx_data_out;
        next_tx_envelope_out = tx_envelope_out;
        next_tx_last_sent = tx_last_sent;
        next_tx_in_ready = fifo_in_ready && !tx_push;
        next_tx_collision = col_s && tx_envelope_out;
        tx_pop = 1'b0;
        if (tx_edge) begin
            case (tx_state)
                TX_IDLE: begin
                    if (fifo_out_valid && !crs_s) begin
                        tx_pop = 1'b1;
                        next_tx_data_out = tx_head.nibble;
                        next_tx_envelope_out = 1'b1;
                        next_tx_last_sent = tx_head.last;
                        next_tx_state = TX_SEND;
                    end
                end
                TX_SEND: begin
                    if (tx_last_sent) begin
                        next_tx_data_out = TXD_RESET;
                        next_tx_envelope_out = 1'b0;
                        next_tx_last_sent = 1'b0;
                        next_tx_state = TX_IDLE;
                    end else if (fifo_out_valid) begin
                        tx_pop = 1'b1;
                        next_tx_data_out = tx_head.nibble;
                        next_tx_last_sent = tx_head.last;
                    end
                    // an underrun holds the last nibble: the frame stays open
                end
                default: begin
                    next_tx_state = TX_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            tx_state <= TX_IDLE;
            tx_data_out <= TXD_RESET;
            tx_envelope_out <= 1'b0;
            tx_last_sent <= 1'b0;
            tx_collision <= 1'b0;
            tx_in_ready <= 1'b0;
        end else begin
            tx_state <= next_tx_state;
            tx_data_out <= next_tx_data_out;
            tx_envelope_out <= next_tx_envelope_out;
            tx_last_sent <= next_tx_last_sent;
            tx_collision <= next_tx_collision;
            tx_in_ready <= next_tx_in_ready;
        end
    end

    // ****************************************************************
    // receive path
    // ****************************************************************
    always_comb begin
        next_rx_state = rx_state;
        next_rx_count = rx_count;
        next_rx_err = rx_err;
        next_rx_nibble = rx_nibble;
        next_rx_nibble_valid = 1'b0;
        next_rx_frame_done = 1'b0;
        next_rx_frame_good = rx_frame_good;
        next_rx_report = rx_report;
        if (rx_edge) begin
            case (rx_state)
                RX_IDLE: begin
                    if (dv_s) begin
                        next_rx_state = RX_RECV;
                        next_rx_count = COUNT_W'(1);
                        next_rx_err = er_s;
                        next_rx_nibble = rxd_s;
                        next_rx_nibble_valid = !er_s;
                    end
                end
                RX_RECV: begin
                    if (dv_s) begin
                        next_rx_count = rx_count + 1'b1;
                        next_rx_err = rx_err || er_s;
                        next_rx_nibble = rxd_s;
                        next_rx_nibble_valid = !(rx_err || er_s);
                    end else begin
                        next_rx_state = RX_IDLE;
                        next_rx_frame_done = 1'b1;
                        next_rx_frame_good = !rx_err;
                        next_rx_report.nibbles = rx_count;
                        next_rx_report.status = rx_status(rx_err, rx_count[0]);
                    end
                end
                default: begin
                    next_rx_state = RX_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            rx_state <= RX_IDLE;
            rx_count <= '0;
            rx_err <= 1'b0;
            rx_nibble <= '0;
            rx_nibble_valid <= 1'b0;
            rx_frame_done <= 1'b0;
            rx_frame_good <= 1'b0;
            rx_report <= '{nibbles: '0, status: STATUS_RESET};
        end else begin
            rx_state <= next_rx_state;
            rx_count <= next_rx_count;
            rx_err <= next_rx_err;
            rx_nibble <= next_rx_nibble;
            rx_nibble_valid <= next_rx_nibble_valid;
            rx_frame_done <= next_rx_frame_done;
            rx_frame_good <= next_rx_frame_good;
            rx_report <= next_rx_report;
        end
    end

    // ****************************************************************
    // phy chip select
    // ****************************************************************
    // host signals share mclk, so no synchroniser; one cycle of latency
    always_comb begin
        next_phy_select_out_n = !in_phy_window(host_access, host_addr, host_bank);
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            phy_select_out_n <= SELECT_IDLE_N;
        end else begin
            phy_select_out_n <= next_phy_select_out_n;
        end
    end
endmodule

/* File: src/miimac_pkg.sv */
package miimac_pkg;

    // ****************************************************************
    // sizes and field positions
    // ****************************************************************
    localparam int NIBBLE_W = 4;
    localparam int STATUS_W = 16;
    localparam int STAT_CRC_BIT = 13;
    localparam int STAT_ODD_BIT = 12;
    localparam int LOW_ADDR_W = 3;
    localparam int BANK_W = 3;
    localparam logic [BANK_W-1:0] PHY_BANK = 3'h7;
    localparam int FIFO_DEPTH = 16;
    localparam int COUNT_W = 11;
    localparam int PIN_SYNC_W = 6 + NIBBLE_W;
    localparam int SYNC_TXC_BIT = 9;
    localparam int SYNC_RXC_BIT = 8;
    localparam int SYNC_CRS_BIT = 7;
    localparam int SYNC_COL_BIT = 6;
    localparam int SYNC_DV_BIT = 5;
    localparam int SYNC_ER_BIT = 4;

    // ****************************************************************
    // reset values
    // ****************************************************************
    localparam logic [NIBBLE_W-1:0] TXD_RESET = 4'h0;
    localparam logic [STATUS_W-1:0] STATUS_RESET = 16'h0000;
    // link clocks and data idle at their pull-up level, the rest at pull-down
    localparam logic [PIN_SYNC_W-1:0] PIN_SYNC_RESET = 10'h30f;
    localparam logic SELECT_IDLE_N = 1'h1;

    typedef struct packed {
        logic last;
        logic [NIBBLE_W-1:0] nibble;
    } miimac_tx_word_t;

    typedef struct packed {
        logic [COUNT_W-1:0] nibbles;
        logic [STATUS_W-1:0] status;
    } miimac_rx_report_t;

endpackage

/* File: src/miimac_fifo.sv */
`timescale 1ns/1ps
module miimac_fifo #(
    parameter int WIDTH = 5,
    parameter int DEPTH = 16
) (
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0] wr_ptr, next_wr_ptr, rd_ptr, next_rd_ptr;
    logic push, pop;

    assign in_ready = (wr_ptr - rd_ptr) != (AW+1)'(DEPTH);
    assign out_valid = wr_ptr != rd_ptr;
    assign out_data = mem[rd_ptr[AW-1:0]];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always_comb begin
        next_wr_ptr = push ? wr_ptr + 1'b1 : wr_ptr;
        next_rd_ptr = pop ? rd_ptr + 1'b1 : rd_ptr;
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
        end else begin
            wr_ptr <= next_wr_ptr;
            rd_ptr <= next_rd_ptr;
        end
    end

    always_ff @(posedge mclk) begin
        if (push) begin
            mem[wr_ptr[AW-1:0]] <= in_data;
        end
    end
endmodule

/* File: verif/miimac_pins_monitor.sv */
`timescale 1ns/1ps
module miimac_pins_monitor
    import miimac_pkg::*;
(
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic host_access,
    input wire logic [LOW_ADDR_W:0] host_addr,
    input wire logic [BANK_W-1:0] host_bank,
    input wire logic phy_select_out_n,
    input wire logic rx_frame_done,
    input wire logic rx_frame_good,
    input wire miimac_rx_report_t rx_report,
    input wire logic [NIBBLE_W-1:0] tx_data_out,
    input wire logic tx_envelope_out,
    input wire logic carrier_sense_in
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_b);
    sequence s_phy; host_access && host_addr < 8 && host_bank == PHY_BANK; endsequence
    property p_sel; s_phy [*2] |-> !phy_select_out_n; endproperty
    property p_idle; (!host_access) [*2] |-> phy_select_out_n; endproperty
    sequence s_frame_end; rx_frame_done; endsequence
    sequence s_tx_start; $rose(tx_envelope_out); endsequence
    property p_bad; s_frame_end ##0 rx_report.status[STAT_CRC_BIT] |-> !rx_frame_good; endproperty
    property p_good; s_frame_end ##0 !rx_report.status[STAT_CRC_BIT] |-> rx_frame_good; endproperty
    property p_done; s_frame_end |=> !rx_frame_done; endproperty
    property p_txd; !tx_envelope_out |-> tx_data_out == TXD_RESET; endproperty
    property p_defer; s_tx_start |-> $past(!carrier_sense_in, 3); endproperty
    a_sel: assert property (p_sel) else $error("select missing");
    a_idle: assert property (p_idle) else $error("select stray");
    a_bad: assert property (p_bad) else $error("bad frame kept");
    a_good: assert property (p_good) else $error("good frame dropped");
    a_done: assert property (p_done) else $error("frame done too long");
    a_txd: assert property (p_txd) else $error("data outside envelope");
    a_defer: assert property (p_defer) else $error("start during carrier");
endmodule

/* File: verif/miimac_phy.sv */
`timescale 1ns/1ps
module miimac_phy (
    output logic rxc,
    output logic dv,
    output logic er,
    output logic [3:0] d,
    output logic txc,
    input wire logic txen,
    input wire logic [3:0] txd
);
    logic [3:0] v;
    logic [3:0] sum = 4'h0;
    logic [3:0] tx_x = 4'h0;
    int tx_cnt = 0;
    // clock parks high and data floats to its pull-up level between frames
    initial {rxc, dv, er, d} = 7'h4f;
    task frame(input logic bad);
        repeat (16) begin
            v = 4'($urandom);
            sum = sum ^ v;
            #100 {rxc, dv, er, d} = {2'b01, bad, v};
            #100 rxc = 1;
        end
        // one idle clock so the mac sees data valid drop on an edge
        #100 {rxc, dv, er, d} = 7'h0f;
        #100 rxc = 1;
    endtask
    // transmit clock runs free, as a phy supplies it continuously
    initial begin
        txc = 1;
        forever #100 txc = ~txc;
    end
    always @(posedge txc) begin
        if (txen === 1'b1) begin
            tx_cnt <= tx_cnt + 1;
            tx_x <= tx_x ^ txd;
        end
    end
endmodule

/* File: verif/miimac_pins_tb.sv */
`timescale 1ns/1ps
module miimac_pins_tb;
    import miimac_pkg::*;
    logic mclk = 0, rst_b = 0, acc = 0, rxc, dv, er, sel_n, done, good;
    logic [3:0] addr = 0, rxd;
    logic [2:0] bank = 0;
    logic txc, crs = 0, col = 0, tx_v = 0, tx_rdy, tx_env, tx_col, nib_v;
    logic [3:0] txd, nib, nb, rx_x = 0, x0, s0, tx_exp;
    miimac_tx_word_t tx_w = '0;
    miimac_rx_report_t rep;
    int n_mismatch = 0, checks_done = 0, rx_cnt = 0, c0;
    miimac_phy phy_u(.rxc(rxc), .dv(dv), .er(er), .d(rxd), .txc(txc), .txen(tx_env), .txd(txd));
    miimac_pins #(.DEPTH(16)) dut_u(.mclk(mclk), .rst_b(rst_b), .tx_nibble_clock(txc),
        .rx_nibble_clock(rxc), .tx_data_out(txd), .tx_envelope_out(tx_env),
        .carrier_sense_in(crs), .collision_in(col), .rx_valid_in(dv), .rx_error_in(er),
        .rx_data_in(rxd), .tx_in_valid(tx_v), .tx_in_ready(tx_rdy), .tx_in_word(tx_w),
        .rx_nibble(nib), .rx_nibble_valid(nib_v), .rx_frame_done(done), .rx_frame_good(good),
        .rx_report(rep), .tx_collision(tx_col), .host_access(acc), .host_addr(addr),
        .host_bank(bank), .phy_select_out_n(sel_n));
    always @(posedge mclk) begin
        if (nib_v === 1'b1) begin
            rx_cnt <= rx_cnt + 1;
            rx_x <= rx_x ^ nib;
        end
    end
    function automatic logic exp_sel(logic a, logic [3:0] ad, logic [2:0] bk);
        return !(a && ad < 8 && bk == PHY_BANK);
    endfunction
    task chk(input logic a, input logic e);
        checks_done++;
        if (a !== e) begin
            n_mismatch++;
            $display("[ERR] %0t mismatch", $time);
        end
    endtask
    task chk_num(input logic [31:0] a, input logic [31:0] e);
        checks_done++;
        if (a !== e) begin
            n_mismatch++;
            $display("[ERR] %0t count mismatch", $time);
        end
    endtask
    // called at an edge; valid stays up until the caller lowers it
    task push(input logic [3:0] n, input logic fin);
        #2 tx_v = 1;
        tx_w = '{last: fin, nibble: n};
        for (int i = 0; i <= 100; i++) begin
            @(posedge mclk);
            if (tx_rdy === 1'b1) break;
            if (i == 100) chk(1'b0, 1'b1);
        end
    endtask
    task complete_run;
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    initial forever #12.5 mclk = ~mclk;
    initial begin
        void'($urandom(32'h6f292c1c));
        repeat (6) @(posedge mclk);
        #2 rst_b = 1;
        repeat (60) begin
            @(posedge mclk) #2 {acc, addr, bank} = 8'($urandom);
            repeat (3) @(posedge mclk);
            chk(sel_n, exp_sel(acc, addr, bank));
        end
        $display("select test done");
        for (int b = 1; b >= 0; b--) begin
            c0 = rx_cnt;
            x0 = rx_x;
            s0 = phy_u.sum;
            fork phy_u.frame(b[0]); join_none
            for (int i = 0; i < 900 && done !== 1'b1; i++) @(posedge mclk) #1;
            chk(done, 1);
            chk(good, !b[0]);
            chk(rep.status[STAT_CRC_BIT], b[0]);
            chk_num(rep.nibbles, 16);
            #4000;
            chk_num(rx_cnt - c0, b[0] ? 0 : 16);
            chk_num(rx_x ^ x0, b[0] ? 4'h0 : phy_u.sum ^ s0);
            $display("frame test done");
        end
        @(posedge mclk) #2 crs = 1;
        tx_exp = 4'h0;
        @(posedge mclk);
        for (int k = 0; k < 5; k++) begin
            nb = (k == 4) ? 4'hf : 4'($urandom);
            tx_exp = tx_exp ^ nb;
            push(nb, k == 4);
        end
        #2 tx_v = 0;
        repeat (40) @(posedge mclk);
        #2 chk(tx_env, 0);
        crs = 0;
        repeat (24) @(posedge mclk);
        #2 col = 1;
        repeat (4) @(posedge mclk);
        #2 chk(tx_col, 1);
        chk(tx_env, 1);
        col = 0;
        for (int i = 0; i < 400 && tx_env !== 1'b0; i++) @(posedge mclk);
        #2 chk(tx_env, 0);
        chk_num(txd, TXD_RESET);
        #400 chk_num(phy_u.tx_cnt, 5);
        chk_num(phy_u.tx_x, tx_exp);
        $display("transmit test done");
        complete_run();
    end
endmodule
bind miimac_pins miimac_pins_monitor mon_u(.mclk(mclk), .rst_b(rst_b), .host_access(host_access),
    .host_addr(host_addr), .host_bank(host_bank), .phy_select_out_n(phy_select_out_n),
    .rx_frame_done(rx_frame_done), .rx_frame_good(rx_frame_good), .rx_report(rx_report),
    .tx_data_out(tx_data_out), .tx_envelope_out(tx_envelope_out),
    .carrier_sense_in(carrier_sense_in));
